// ==== rtl/sfc_defines.svh ====
// Opcodes, bit masks, reset values and timing counts for the serial flash command block.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_OP_POLL  8'h25
`define SFC_OP_WRITE_ENABLE_CMD  8'h06
`define SFC_OP_STATUS_WRITE_CMD  8'h01
`define SFC_OP_CONFIG_WRITE_CMD  8'h31
`define SFC_OP_READ  8'h03
`define SFC_OP_FAST  8'h0b
`define SFC_OP_DUAL  8'h3b
`define SFC_OP_RDSR  8'h05
`define SFC_OP_RDSR2 8'h35
`define SFC_OP_RDCR  8'h15
`define SFC_ST_KEEP  16'h8403
`define SFC_ST_CLR8  16'h4300
`define SFC_ST_RST   16'h0000
`define SFC_CR_RST   8'h00
`define SFC_STATUS_PROTECT_BIT0_BIT 7
`define SFC_STATUS_PROTECT_BIT1_BIT 8
`define SFC_ADDR_BITS 5'h18
`define SFC_DUMMY_BITS 5'h08
`define SFC_WR_SHORT 5'h08
`define SFC_WR_LONG  5'h10
`define SFC_SYNC_RST 4'hb
`define SFC_CLK_NS   20
`define SFC_TW_NS    10000
`define SFC_TW_CYC   ((`SFC_TW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_HALF_CYC 8
`endif

// ==== rtl/sfc_pkg.sv ====
// Types shared by the flash end and the host end.
package sfc_pkg;
	typedef enum logic [2:0] {
		SFC_D_OPC, SFC_D_ADDR, SFC_D_DUMMY, SFC_D_DATA, SFC_D_POLL, SFC_D_WDATA, SFC_D_SKIP
	} sfc_dstate_e;
	typedef enum logic [2:0] {
		SFC_H_IDLE, SFC_H_LEAD, SFC_H_LO, SFC_H_HI, SFC_H_POLL, SFC_H_TAIL
	} sfc_hstate_e;
endpackage : sfc_pkg

// ==== rtl/sfc_if.sv ====
// Serial link between host and flash, with the resolved levels of the two data lines.
`timescale 1ns/1ps
interface sfc_if;
	logic cs_n;
	logic sck;
	logic io0_h;
	logic io0_h_oe;
	logic io0_d;
	logic io0_d_oe;
	logic io1_d;
	logic io1_d_oe;
	logic io0;
	logic io1;
	// Undriven lines rest high.
	assign io0 = io0_h_oe ? io0_h : (io0_d_oe ? io0_d : 1'b1);
	assign io1 = io1_d_oe ? io1_d : 1'b1;
	modport flash (input cs_n, sck, io0, output io0_d, io0_d_oe, io1_d, io1_d_oe);
	modport host (output cs_n, sck, io0_h, io0_h_oe, input io0, io1);
endinterface : sfc_if

// ==== rtl/sfc_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module sfc_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Pins in, synchronised out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sfc_sync

// ==== rtl/sfc_flash.sv ====
// Flash end: busy poll, register writes with self-timed cycle, single, fast and dual reads.
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_flash #(
	parameter int MEM_AW = 16,
	parameter int TW_CYC = `SFC_TW_CYC
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Serial link.
	sfc_if.flash      lnk,
	// Write protect pin and busy indication.
	input  wire logic wp_n,
	output logic      busy
);
	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic cs_n_s;
	logic sck_s;
	logic si_s;
	logic wp_n_s;
	logic sck_q;
	logic cs_n_q;
	sfc_sync #(.W(4), .INIT(`SFC_SYNC_RST)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({lnk.cs_n, lnk.sck, lnk.io0, wp_n}),
		.q   ({cs_n_s, sck_s, si_s, wp_n_s})
	);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sck_q  <= sck_s;
			cs_n_q <= cs_n_s;
		end
	end
	wire rise    = sck_s & ~sck_q & ~cs_n_s;
	wire fall    = ~sck_s & sck_q & ~cs_n_s;
	wire cs_rise = cs_n_s & ~cs_n_q;

	// ----------------------------------------------------------------
	// Command state
	// ----------------------------------------------------------------
	sfc_pkg::sfc_dstate_e st_q;
	logic [7:0]        op_q;
	logic [23:0]       sh_q;
	logic [4:0]        bcnt_q;
	logic [MEM_AW-1:0] addr_q;
	logic [7:0]        byte_q;
	logic [2:0]        ocnt_q;
	logic [15:0]       stat_q;
	logic [7:0]        cfg_q;
	logic              wel_q;
	logic              wip_q;
	logic [31:0]       tmr_q;
	wire  [7:0]        op_in   = {sh_q[6:0], si_s};
	wire  [23:0]       addr_in = {sh_q[22:0], si_s};
	wire               dual    = (op_q == `SFC_OP_DUAL);
	wire  [2:0]        step    = dual ? 3'h2 : 3'h1;
	wire               prot    = stat_q[`SFC_STATUS_PROTECT_BIT1_BIT]
	                           | (stat_q[`SFC_STATUS_PROTECT_BIT0_BIT] & ~wp_n_s);

	function automatic logic [7:0] fetch(input logic [7:0] op, input logic [MEM_AW-1:0] a);
		case (op)
			`SFC_OP_RDSR:  fetch = {stat_q[7:2], wel_q, wip_q};
			`SFC_OP_RDSR2: fetch = stat_q[15:8];
			`SFC_OP_RDCR:  fetch = cfg_q;
			default:       fetch = 8'(a) ^ 8'(a >> 8);
		endcase
	endfunction : fetch

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q   <= sfc_pkg::SFC_D_OPC;
			op_q   <= 8'h00;
			sh_q   <= 24'h000000;
			bcnt_q <= 5'h00;
			addr_q <= '0;
			byte_q <= 8'h00;
			ocnt_q <= 3'h0;
		end else if (cs_n_s) begin
			st_q   <= sfc_pkg::SFC_D_OPC;
			bcnt_q <= 5'h00;
			ocnt_q <= 3'h0;
		end else if (rise) begin
			case (st_q)
				sfc_pkg::SFC_D_OPC: begin
					sh_q   <= addr_in;
					bcnt_q <= bcnt_q + 5'h01;
					if (bcnt_q == 5'h07) begin
						op_q   <= op_in;
						bcnt_q <= 5'h00;
						case (op_in)
							`SFC_OP_POLL: st_q <= sfc_pkg::SFC_D_POLL;
							`SFC_OP_READ: st_q <= sfc_pkg::SFC_D_ADDR;
							`SFC_OP_FAST, `SFC_OP_DUAL: begin
								st_q <= wip_q ? sfc_pkg::SFC_D_SKIP
								              : sfc_pkg::SFC_D_ADDR;
							end
							`SFC_OP_STATUS_WRITE_CMD, `SFC_OP_CONFIG_WRITE_CMD: st_q <= sfc_pkg::SFC_D_WDATA;
							`SFC_OP_RDSR, `SFC_OP_RDSR2, `SFC_OP_RDCR: begin
								st_q   <= sfc_pkg::SFC_D_DATA;
								byte_q <= fetch(op_in, addr_q);
							end
							default: st_q <= sfc_pkg::SFC_D_SKIP;
						endcase
					end
				end
				sfc_pkg::SFC_D_ADDR: begin
					sh_q   <= addr_in;
					bcnt_q <= bcnt_q + 5'h01;
					if (bcnt_q == `SFC_ADDR_BITS - 5'h01) begin
						addr_q <= addr_in[MEM_AW-1:0];
						bcnt_q <= 5'h00;
						if (op_q == `SFC_OP_READ) begin
							st_q   <= sfc_pkg::SFC_D_DATA;
							byte_q <= fetch(op_q, addr_in[MEM_AW-1:0]);
						end else begin
							st_q <= sfc_pkg::SFC_D_DUMMY;
						end
					end
				end
				sfc_pkg::SFC_D_DUMMY: begin
					bcnt_q <= bcnt_q + 5'h01;
					if (bcnt_q == `SFC_DUMMY_BITS - 5'h01) begin
						st_q   <= sfc_pkg::SFC_D_DATA;
						byte_q <= fetch(op_q, addr_q);
					end
				end
				sfc_pkg::SFC_D_WDATA: begin
					sh_q <= addr_in;
					if (bcnt_q != 5'h1f) begin
						bcnt_q <= bcnt_q + 5'h01;
					end
				end
				default: begin
					bcnt_q <= bcnt_q;
				end
			endcase
		end else if (fall && st_q == sfc_pkg::SFC_D_DATA) begin
			ocnt_q <= ocnt_q + step;
			if (ocnt_q + step == 3'h0) begin
				addr_q <= addr_q + 1'b1;
				byte_q <= fetch(op_q, addr_q + 1'b1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Output lines
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lnk.io1_d    <= 1'b0;
			lnk.io1_d_oe <= 1'b0;
			lnk.io0_d    <= 1'b0;
			lnk.io0_d_oe <= 1'b0;
		end else if (cs_n_s) begin
			lnk.io1_d_oe <= 1'b0;
			lnk.io0_d_oe <= 1'b0;
		end else if (st_q == sfc_pkg::SFC_D_POLL) begin
			lnk.io1_d    <= wip_q;
			lnk.io1_d_oe <= 1'b1;
		end else if (fall && st_q == sfc_pkg::SFC_D_DATA) begin
			lnk.io1_d    <= byte_q[3'h7 - ocnt_q];
			lnk.io1_d_oe <= 1'b1;
			lnk.io0_d    <= byte_q[3'h6 - ocnt_q];
			lnk.io0_d_oe <= dual;
		end
	end

	// ----------------------------------------------------------------
	// Registers and self-timed write cycle
	// ----------------------------------------------------------------
	wire        wr_end  = cs_rise && st_q == sfc_pkg::SFC_D_WDATA && wel_q;
	wire        wr_stat = wr_end && op_q == `SFC_OP_STATUS_WRITE_CMD && !prot
	                   && (bcnt_q == `SFC_WR_SHORT || bcnt_q == `SFC_WR_LONG);
	wire        wr_cfg  = wr_end && op_q == `SFC_OP_CONFIG_WRITE_CMD && bcnt_q == `SFC_WR_SHORT;
	wire [7:0]  clr8    = 8'(`SFC_ST_CLR8 >> 8);
	wire [15:0] nv      = (bcnt_q == `SFC_WR_LONG) ? {sh_q[7:0], sh_q[15:8]}
	                    : {stat_q[15:8] & ~clr8, sh_q[7:0]};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_q <= `SFC_ST_RST;
			cfg_q  <= `SFC_CR_RST;
			wel_q  <= 1'b0;
			wip_q  <= 1'b0;
			tmr_q  <= 32'h0;
		end else if (wip_q) begin
			tmr_q <= tmr_q + 32'h1;
			if (tmr_q == 32'(TW_CYC - 1)) begin
				wip_q <= 1'b0;
				wel_q <= 1'b0;
			end
		end else if (cs_rise) begin
			tmr_q <= 32'h0;
			if (st_q == sfc_pkg::SFC_D_SKIP && bcnt_q == 5'h00 && op_q == `SFC_OP_WRITE_ENABLE_CMD) begin
				wel_q <= 1'b1;
			end
			if (wr_stat) begin
				stat_q <= (nv & ~`SFC_ST_KEEP) | (stat_q & `SFC_ST_KEEP);
				wip_q  <= 1'b1;
			end
			if (wr_cfg) begin
				cfg_q <= sh_q[7:0];
				wip_q <= 1'b1;
			end
		end
	end
	assign busy = wip_q;
endmodule : sfc_flash

// ==== rtl/sfc_host.sv ====
// Host end: issues one command frame, with optional single or dual reads and busy polling.
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_host #(
	parameter int   HALF      = `SFC_HALF_CYC,
	parameter logic IDLE_HIGH = 1'b0
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial link.
	sfc_if.host              lnk,
	// Command request.
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_op,
	input  wire logic [31:0] cmd_tx,
	input  wire logic [2:0]  cmd_ntx,
	input  wire logic [7:0]  cmd_nrx,
	input  wire logic        cmd_dual,
	input  wire logic        cmd_poll,
	// Answer.
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output logic             done
);
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	sfc_pkg::sfc_hstate_e st_q;
	logic [1:0]  rx_s;
	logic [31:0] hcnt_q;
	logic [11:0] ccnt_q;
	logic [11:0] txc_q;
	logic [11:0] tot_q;
	logic        dual_q;
	logic        poll_q;
	logic [39:0] tx_q;
	logic [2:0]  rbit_q;
	logic [7:0]  rsh_q;
	sfc_sync #(.W(2), .INIT(2'h3)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({lnk.io1, lnk.io0}),
		.q   (rx_s)
	);
	wire        half  = (hcnt_q == 32'(HALF - 1));
	wire        last  = (ccnt_q + 12'h1 == tot_q);
	wire        go_lo = half && (st_q == sfc_pkg::SFC_H_LEAD
	                  || (st_q == sfc_pkg::SFC_H_HI && !last));
	wire [11:0] cnext = (st_q == sfc_pkg::SFC_H_LEAD) ? 12'h0 : ccnt_q + 12'h1;
	wire [11:0] rxc   = cmd_dual ? {2'h0, cmd_nrx, 2'h0} : {1'h0, cmd_nrx, 3'h0};
	wire [11:0] txc   = 12'({cmd_ntx, 3'h0}) + 12'h8;
	wire [11:0] extra = {11'h0, cmd_poll & IDLE_HIGH};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= sfc_pkg::SFC_H_IDLE;
			hcnt_q    <= 32'h0;
			ccnt_q    <= 12'h0;
			txc_q     <= 12'h0;
			tot_q     <= 12'h0;
			dual_q    <= 1'b0;
			poll_q    <= 1'b0;
			cmd_ready <= 1'b1;
			done      <= 1'b0;
			lnk.cs_n  <= 1'b1;
			lnk.sck   <= IDLE_HIGH;
		end else begin
			done   <= 1'b0;
			hcnt_q <= half ? 32'h0 : hcnt_q + 32'h1;
			case (st_q)
				sfc_pkg::SFC_H_IDLE: begin
					hcnt_q <= 32'h0;
					if (cmd_valid) begin
						st_q      <= sfc_pkg::SFC_H_LEAD;
						cmd_ready <= 1'b0;
						lnk.cs_n  <= 1'b0;
						txc_q     <= txc;
						tot_q     <= txc + rxc + extra;
						dual_q    <= cmd_dual;
						poll_q    <= cmd_poll;
					end
				end
				sfc_pkg::SFC_H_LEAD, sfc_pkg::SFC_H_LO: begin
					if (half) begin
						st_q    <= (go_lo) ? sfc_pkg::SFC_H_LO : sfc_pkg::SFC_H_HI;
						lnk.sck <= !go_lo;
						ccnt_q  <= go_lo ? cnext : ccnt_q;
					end
				end
				sfc_pkg::SFC_H_HI: begin
					if (half) begin
						ccnt_q  <= cnext;
						lnk.sck <= last & IDLE_HIGH;
						if (last) begin
							st_q <= poll_q ? sfc_pkg::SFC_H_POLL : sfc_pkg::SFC_H_TAIL;
						end else begin
							st_q <= sfc_pkg::SFC_H_LO;
						end
					end
				end
				sfc_pkg::SFC_H_POLL: begin
					hcnt_q <= 32'h0;
					if (!rx_s[1]) begin
						st_q <= sfc_pkg::SFC_H_TAIL;
					end
				end
				sfc_pkg::SFC_H_TAIL: begin
					if (half) begin
						st_q      <= sfc_pkg::SFC_H_IDLE;
						lnk.cs_n  <= 1'b1;
						cmd_ready <= 1'b1;
						done      <= 1'b1;
					end
				end
				default: st_q <= sfc_pkg::SFC_H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Input line drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_q         <= 40'h0;
			lnk.io0_h    <= 1'b0;
			lnk.io0_h_oe <= 1'b0;
		end else if (st_q == sfc_pkg::SFC_H_IDLE && cmd_valid) begin
			tx_q <= {cmd_op, cmd_tx};
		end else if (go_lo) begin
			if (cnext < txc_q) begin
				lnk.io0_h    <= tx_q[39];
				lnk.io0_h_oe <= 1'b1;
				tx_q         <= {tx_q[38:0], 1'b0};
			end else if (dual_q) begin
				lnk.io0_h_oe <= 1'b0;
			end
		end else if (st_q == sfc_pkg::SFC_H_TAIL && half) begin
			lnk.io0_h_oe <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read capture
	// ----------------------------------------------------------------
	wire [2:0] rstep = dual_q ? 3'h2 : 3'h1;
	wire [7:0] rnext = dual_q ? {rsh_q[5:0], rx_s} : {rsh_q[6:0], rx_s[1]};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rbit_q   <= 3'h0;
			rsh_q    <= 8'h00;
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else begin
			rd_valid <= 1'b0;
			if (st_q == sfc_pkg::SFC_H_IDLE) begin
				rbit_q <= 3'h0;
			end else if (st_q == sfc_pkg::SFC_H_HI && half && ccnt_q >= txc_q && !poll_q) begin
				rsh_q  <= rnext;
				rbit_q <= rbit_q + rstep;
				if (rbit_q + rstep == 3'h0) begin
					rd_valid <= 1'b1;
					rd_data  <= rnext;
				end
			end
		end
	end
endmodule : sfc_host

// ==== verification/sfc_link_assertions.sv ====
// Concurrent checks on the serial link and the flash busy flag.
`timescale 1ns/1ps
module sfc_link_assertions #(
	parameter int TW_CYC = 20
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link signals and busy flag.
	input wire logic cs_n,
	input wire logic sck,
	input wire logic io0_h_oe,
	input wire logic io0_d_oe,
	input wire logic io1_d_oe,
	input wire logic busy
);
	logic [15:0] bcnt_q;
	logic [3:0]  rise_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Counters of busy cycles and of cycles since deselection.
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) bcnt_q <= 16'h0000;
		else bcnt_q <= busy ? bcnt_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rise_q <= 4'hf;
		else if ($rose(cs_n)) rise_q <= 4'h0;
		else if (rise_q != 4'hf) rise_q <= rise_q + 4'h1;
	end
	// ----------------------------------------
	// Assertions and covers.
	// ----------------------------------------
	a_idle_released: assert property (cs_n [*8] |-> !io1_d_oe && !io0_d_oe)
		else $error("flash drives the link while deselected");
	a_drive_selected: assert property ($rose(io1_d_oe) |-> !cs_n)
		else $error("flash starts driving while deselected");
	a_no_line_clash: assert property (!(io0_h_oe && io0_d_oe))
		else $error("host and flash both drive line 0");
	a_dual_pairs: assert property (io0_d_oe |-> io1_d_oe)
		else $error("line 0 driven without line 1");
	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("serial clock not idle while deselected");
	a_sck_half_phase: assert property ($changed(sck) |=> $stable(sck) [*7])
		else $error("serial clock phase shorter than eight cycles");
	a_busy_after_frame: assert property ($rose(busy) |-> rise_q >= 4'h1 && rise_q <= 4'hc)
		else $error("busy rose away from a deselection");
	a_busy_bounded: assert property (busy |-> bcnt_q < TW_CYC + 2)
		else $error("write cycle runs too long");
	a_busy_full_span: assert property ($fell(busy) |-> bcnt_q >= TW_CYC - 2)
		else $error("write cycle ends too early");
	c_write_cycle: cover property ($rose(busy));
	c_dual_out: cover property ($rose(io0_d_oe));
	c_poll_end: cover property ($fell(busy) && !cs_n);
endmodule : sfc_link_assertions

// ==== verification/sfc_tb.sv ====
// Self-checking bench: host end and flash end joined over the serial link.
`timescale 1ns/1ps
module sfc_tb;
	localparam int TW = 2000;
	logic        clk;
	logic        rst;
	logic        wp_n;
	logic        busy;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  cmd_op;
	logic [31:0] cmd_tx;
	logic [2:0]  cmd_ntx;
	logic [7:0]  cmd_nrx;
	logic        cmd_dual;
	logic        cmd_poll;
	logic        rd_valid;
	logic [7:0]  rd_data;
	logic        done;
	logic [7:0]  rxq[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	sfc_if sfc_if_i ();
	sfc_flash #(.MEM_AW(16), .TW_CYC(TW)) sfc_flash_i (
		.clk(clk), .rst(rst), .lnk(sfc_if_i), .wp_n(wp_n), .busy(busy)
	);
	sfc_host #(.HALF(8), .IDLE_HIGH(1'b0)) sfc_host_i (
		.clk(clk), .rst(rst), .lnk(sfc_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_tx(cmd_tx), .cmd_ntx(cmd_ntx), .cmd_nrx(cmd_nrx),
		.cmd_dual(cmd_dual), .cmd_poll(cmd_poll), .rd_valid(rd_valid), .rd_data(rd_data),
		.done(done)
	);
	sfc_link_assertions #(.TW_CYC(TW)) sfc_link_assertions_i (
		.clk(clk), .rst(rst), .cs_n(sfc_if_i.cs_n), .sck(sfc_if_i.sck),
		.io0_h_oe(sfc_if_i.io0_h_oe), .io0_d_oe(sfc_if_i.io0_d_oe),
		.io1_d_oe(sfc_if_i.io1_d_oe), .busy(busy)
	);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rd_valid === 1'b1) rxq.push_back(rd_data);
	end
	// ----------------------------------------
	// Command tasks and compares.
	// ----------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask : chk1
	task automatic xfer(input logic [7:0] op, input logic [31:0] tx, input logic [2:0] ntx,
		input logic [7:0] nrx, input logic dual, input logic poll);
		int n;
		n = 0;
		rxq.delete();
		@(negedge clk);
		{cmd_op, cmd_tx, cmd_ntx, cmd_nrx, cmd_dual, cmd_poll} = {op, tx, ntx, nrx, dual, poll};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 30000) begin
			@(negedge clk);
			n++;
		end
		if (n == 30000) begin
			n_errors++;
			print_verdict();
		end
		chk1("host idle after frame", 1'b1, cmd_ready);
	endtask : xfer
	task automatic cmd(input logic [7:0] op, input logic [31:0] tx, input logic [2:0] ntx);
		xfer(op, tx, ntx, 8'h00, 1'b0, op == 8'h25);
	endtask : cmd
	task automatic stat(input logic [7:0] op, input logic [7:0] e, input logic [7:0] m);
		xfer(op, 32'h0, 3'h0, 8'h01, 1'b0, 1'b0);
		chk8("register", e, rxq[0] & m);
	endtask : stat
	task automatic rdchk(input logic [7:0] op, input logic [31:0] tx, input logic [2:0] ntx,
		input logic dual, input logic [15:0] a);
		xfer(op, tx, ntx, 8'h03, dual, 1'b0);
		for (int i = 0; i < 3; i++) begin
			chk8("read byte", a[7:0] ^ a[15:8], rxq[i]);
			a++;
		end
	endtask : rdchk
	task automatic tend(input string s);
		$display("test %s finished", s);
	endtask : tend
	// ----------------------------------------
	// Test sequence and watchdog.
	// ----------------------------------------
	initial begin
		{cmd_valid, cmd_op, cmd_tx, cmd_ntx, cmd_nrx, cmd_dual, cmd_poll} = '0;
		wp_n = 1'b1;
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		rdchk(8'h03, 32'h00fffe00, 3'h3, 1'b0, 16'hfffe);
		rdchk(8'h0b, 32'h00123400, 3'h4, 1'b0, 16'h1234);
		rdchk(8'h3b, 32'h00ffff00, 3'h4, 1'b1, 16'hffff);
		tend("reads");
		cmd(8'h01, 32'hff000000, 3'h1);
		stat(8'h05, 8'h00, 8'hff);
		cmd(8'h06, 32'h0, 3'h0);
		stat(8'h05, 8'h02, 8'hff);
		cmd(8'h01, 32'h7fc60000, 3'h2);
		stat(8'h05, 8'h01, 8'h01);
		xfer(8'h0b, 32'h00123400, 3'h4, 8'h01, 1'b0, 1'b0);
		chk8("refused read", 8'hff, rxq[0]);
		cmd(8'h25, 32'h0, 3'h0);
		chk1("busy after poll", 1'b0, busy);
		stat(8'h05, 8'h7c, 8'hff);
		stat(8'h35, 8'h42, 8'hff);
		tend("status write");
		cmd(8'h06, 32'h0, 3'h0);
		cmd(8'h01, 32'h00000000, 3'h3);
		stat(8'h05, 8'h7e, 8'hff);
		cmd(8'h01, 32'h1c000000, 3'h1);
		cmd(8'h25, 32'h0, 3'h0);
		stat(8'h05, 8'h1c, 8'hff);
		stat(8'h35, 8'h00, 8'hff);
		tend("write length");
		cmd(8'h06, 32'h0, 3'h0);
		cmd(8'h31, 32'h80550000, 3'h2);
		stat(8'h15, 8'h00, 8'hff);
		cmd(8'h31, 32'h80000000, 3'h1);
		stat(8'h05, 8'h03, 8'h03);
		cmd(8'h25, 32'h0, 3'h0);
		stat(8'h15, 8'h80, 8'hff);
		stat(8'h05, 8'h1c, 8'hff);
		tend("config write");
		cmd(8'h06, 32'h0, 3'h0);
		cmd(8'h01, 32'h80000000, 3'h1);
		cmd(8'h25, 32'h0, 3'h0);
		wp_n = 1'b0;
		cmd(8'h06, 32'h0, 3'h0);
		cmd(8'h01, 32'h9c000000, 3'h1);
		stat(8'h05, 8'h82, 8'hff);
		tend("protection");
		print_verdict();
	end
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
endmodule : sfc_tb
